// ### smeab_pkg.sv
// Constants, register map and pin bundles for the serial module enable and slave abort block.
// Assumes a classic Wishbone master with 32-bit data; registers are 8 bits wide, in byte lane 0.
// How it works
// (R1) Control bit 1: one enables, zero disables
// (R2) Disabled: pins lose serial function entirely
// (R3) Disabled: all serial activity stopped, idle
// (R4) SPI enable rise keeps control contents
// (R5) Software should initialise settings before enabling
// (R6) I2C enable rise keeps direction, ack bits
// (R7) I2C enable rise resets bus status flags
// (R8) Incomplete flag only in SPI slave mode
// (R9) Early select rise sets incomplete and complete
// (R10) Incomplete abort raises interrupt when enabled
// (R11) Software setting incomplete leaves complete alone
// (R12) Polarity bit one means clock idles low
// (R13) Slave mode: external master supplies clock
// (R14) Select pin used only when enabled
// (R15) Eight shifted bits finish a slave transfer
package smeab_pkg;
   // Register byte addresses, one aligned word each
   localparam logic [7:0] ADDR_MODE_CTRL   = 8'h00; // serial_mode_enable_control
   localparam logic [7:0] ADDR_I2C_CTRL    = 8'h04; // I2C control and status flags
   localparam logic [7:0] ADDR_SPI_CTRL    = 8'h08; // spi_format_and_flags_control
   localparam logic [7:0] ADDR_DATA        = 8'h0c; // Shift data register
   localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h10; // Sticky event bits, write one to clear
   localparam logic [7:0] ADDR_IRQ_MASK    = 8'h14; // Event mask, same layout
   // Mode control fields
   localparam int MODE_SEL_MSB   = 7;
   localparam int MODE_SEL_LSB   = 5;
   localparam int MODE_EN_BIT    = 1;
   localparam int MODE_ICF_BIT   = 0;
   localparam logic [7:0] MODE_CTRL_RST  = 8'he0;
   localparam logic [7:0] MODE_CTRL_MASK = 8'hef; // Bit 4 unimplemented, reads zero
   localparam logic [2:0] MODE_SPI_SLAVE = 3'h5;
   localparam logic [2:0] MODE_I2C_SLAVE = 3'h6;
   localparam logic [2:0] MODE_NONE      = 3'h7;
   // SPI control fields
   localparam int SPI_POL_BIT    = 5;
   localparam int SPI_EDGE_BIT   = 4;
   localparam int SPI_ORDER_BIT  = 3;
   localparam int SPI_SELECT_PIN_ENABLE_BIT   = 2;
   localparam int SPI_WRITE_COLLISION_FLAG_BIT   = 1;
   localparam int SPI_TRF_BIT    = 0;
   localparam logic [7:0] SPI_CTRL_RST = 8'h00;
   // I2C control: bits 7..6 kept, bits 4..0 status flags
   localparam int I2C_HTX_BIT    = 7;
   localparam int I2C_I2C_ACK_TRANSMIT_BIT   = 6;
   localparam logic [7:0] I2C_KEEP_MASK  = 8'hc0;
   localparam logic [7:0] I2C_FLAG_MASK  = 8'h1f;
   localparam logic [7:0] I2C_FLAG_RST   = 8'h01; // Received-ack idles high
   localparam logic [7:0] I2C_CTRL_RST   = 8'h01;
   // Interrupt bits
   localparam int IRQ_TRF_BIT    = 0;
   localparam int IRQ_ICF_BIT    = 1;
   localparam logic [1:0] IRQ_RST = 2'h0;
   // Transfer length
   localparam logic [2:0] BIT_CNT_LAST = 3'h7;
   localparam logic [2:0] BIT_CNT_ZERO = 3'h0;

   // Pins seen from outside the clock domain
   typedef struct packed {
      logic sck;
      logic sdi;
      logic scs_n;
   } smeab_pins_in_s;

   // Pins driven by the block, clock and data each with its enable, plus the function select
   typedef struct packed {
      logic sck;
      logic sck_oe;
      logic sdo;
      logic sdo_oe;
      logic serial_func;
   } smeab_pins_out_s;
endpackage

// ### smeab_top.sv
// Enable control, SPI slave abort detection and register file of the combined serial module.
// Assumes a classic Wishbone master on clk_i and an external SPI master whose pins are asynchronous.
`timescale 1ns/10ps
module smeab_top
   import smeab_pkg::*;
(
   input  wire logic            clk_i,      // 10 MHz system clock
   input  wire logic            rst_i,      // Synchronous, active high
   input  wire logic            wb_cyc_i,   // Wishbone cycle
   input  wire logic            wb_stb_i,   // Wishbone strobe
   input  wire logic            wb_we_i,    // Write enable
   input  wire logic [7:0]      wb_adr_i,   // Byte address
   input  wire logic [3:0]      wb_sel_i,   // Byte lanes
   input  wire logic [31:0]     wb_dat_i,   // Write data
   output logic      [31:0]     wb_dat_o,   // Read data
   output logic                 wb_ack_o,   // Acknowledge
   input  wire smeab_pins_in_s  pins_i,     // Raw pin levels
   output smeab_pins_out_s      pins_o,     // Pin drive and function select
   output logic                 irq_o       // Level interrupt
);

   // Register state
   logic [7:0] mode_ctrl_r;     // serial_mode_enable_control
   logic [7:0] spi_ctrl_r;      // spi_format_and_flags_control
   logic [7:0] i2c_ctrl_r;      // I2C control and flags
   logic [7:0] data_r;          // Shift data register
   logic [1:0] irq_status_r;    // Sticky events
   logic [1:0] irq_mask_r;      // Event mask
   logic       ack_r;           // Bus acknowledge
   logic [31:0] rdata_r;        // Registered read data
   logic       en_d_r;          // Enable delayed, for rise detection

   // Synchronisers, first stage read by second stage only
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic       sck_prev_r;      // Last synchronised clock level
   logic       scs_prev_r;      // Last synchronised select level

   // Slave shift state
   logic [2:0] bit_cnt_r;       // Bits shifted in this byte
   logic [7:0] shift_r;         // Receive shifter
   logic [7:0] tx_r;            // Transmit shifter
   logic       sdo_r;           // Output data bit

   // Decoded controls
   logic [2:0] mode_sel;
   logic       module_enable;
   logic       is_spi_slave;
   logic       is_spi_master;
   logic       is_i2c;
   logic       clock_idle_polarity;
   logic       clock_active_edge;
   logic       bit_order_select;
   logic       select_pin_enable;
   logic       en_rise;

   // Bus strobes
   logic       bus_req;
   logic       wr_en;
   logic [7:0] wdat;

   // Synchronised pins and derived events
   logic       sck_s;
   logic       sdi_s;
   logic       scs_n_s;
   logic       selected;
   logic       sck_rise;
   logic       sck_fall;
   logic       sample_edge;
   logic       shift_edge;
   logic       byte_done;
   logic       abort_evt;
   logic       sw_icf_set;

   // Field decode
   assign mode_sel            = mode_ctrl_r[MODE_SEL_MSB:MODE_SEL_LSB];
   // (R1) Enable bit decode
   assign module_enable       = mode_ctrl_r[MODE_EN_BIT];
   assign is_spi_slave        = (mode_sel == MODE_SPI_SLAVE);
   assign is_i2c              = (mode_sel == MODE_I2C_SLAVE);
   assign is_spi_master       = (mode_sel < MODE_SPI_SLAVE);
   assign clock_idle_polarity = spi_ctrl_r[SPI_POL_BIT];
   assign clock_active_edge   = spi_ctrl_r[SPI_EDGE_BIT];
   assign bit_order_select    = spi_ctrl_r[SPI_ORDER_BIT];
   assign select_pin_enable   = spi_ctrl_r[SPI_SELECT_PIN_ENABLE_BIT];
   assign en_rise             = module_enable & ~en_d_r;

   // Wishbone strobes; writes land on the acknowledging edge
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign wr_en   = bus_req & wb_we_i & ack_r & wb_sel_i[0];
   assign wdat    = wb_dat_i[7:0];

   // Synchronised pin levels
   assign sck_s   = sync2_r[2];
   assign sdi_s   = sync2_r[1];
   assign scs_n_s = sync2_r[0];

   // (R14) Select pin honoured only when enabled, else ignored as floating
   // (R3) No slave activity while disabled
   assign selected = module_enable & is_spi_slave & select_pin_enable & ~scs_n_s;

   // (R13) Slave clock edges come from the external master
   assign sck_rise    = sck_s & ~sck_prev_r;
   assign sck_fall    = ~sck_s & sck_prev_r;
   // Active edge bit picks the sampling edge; the other edge launches data
   assign sample_edge = clock_active_edge ? sck_rise : sck_fall;
   assign shift_edge  = clock_active_edge ? sck_fall : sck_rise;

   // (R15) Eighth sampled bit finishes the byte
   assign byte_done = selected & sample_edge & (bit_cnt_r == BIT_CNT_LAST);

   // (R9) Select released with a partial byte, module and select enabled
   // (R8) Only detectable in SPI slave mode
   assign abort_evt = module_enable & is_spi_slave & select_pin_enable & scs_n_s & ~scs_prev_r
                      & (bit_cnt_r != BIT_CNT_ZERO);

   // (R11) Software write of one to incomplete flag
   assign sw_icf_set = wr_en & (wb_adr_i == ADDR_MODE_CTRL) & wdat[MODE_ICF_BIT];

   // Bus acknowledge, one cycle after request, dropped after one cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= bus_req & ~ack_r;
      end
   end

   // Read data mux, registered; unmapped addresses read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_r <= 32'h0000_0000;
      end else if (bus_req & ~ack_r) begin
         case (wb_adr_i)
            ADDR_MODE_CTRL:  rdata_r <= {24'h00_0000, mode_ctrl_r & MODE_CTRL_MASK};
            ADDR_I2C_CTRL:   rdata_r <= {24'h00_0000, i2c_ctrl_r};
            ADDR_SPI_CTRL:   rdata_r <= {24'h00_0000, spi_ctrl_r};
            ADDR_DATA:       rdata_r <= {24'h00_0000, data_r};
            ADDR_IRQ_STATUS: rdata_r <= {30'h0000_0000, irq_status_r};
            ADDR_IRQ_MASK:   rdata_r <= {30'h0000_0000, irq_mask_r};
            default:         rdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // Mode control register; hardware abort sets the flag and wins over a clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_ctrl_r <= MODE_CTRL_RST;
      end else begin
         if (wr_en & (wb_adr_i == ADDR_MODE_CTRL)) begin
            mode_ctrl_r <= wdat & MODE_CTRL_MASK;
         end
         // (R9) Abort sets incomplete flag
         if (abort_evt) begin
            mode_ctrl_r[MODE_ICF_BIT] <= 1'b1;
         end
      end
   end

   // Enable history for rise detection
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         en_d_r <= 1'b0;
      end else begin
         en_d_r <= module_enable;
      end
   end

   // SPI control register; kept across enable rises, never reloaded
   // (R4) No default reload on enable
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         spi_ctrl_r <= SPI_CTRL_RST;
      end else begin
         if (wr_en & (wb_adr_i == ADDR_SPI_CTRL)) begin
            spi_ctrl_r <= wdat;
         end
         // (R11) Complete flag set by hardware or by a direct register write, never by software setting incomplete
         // (R9) Abort and finished byte both set complete flag
         if (abort_evt | byte_done) begin
            spi_ctrl_r[SPI_TRF_BIT] <= 1'b1;
         end
      end
   end

   // I2C control and flags
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         i2c_ctrl_r <= I2C_CTRL_RST;
      end else if (en_rise & is_i2c) begin
         // (R6) Direction and ack-transmit kept
         // (R7) Status flags to defaults
         i2c_ctrl_r <= (i2c_ctrl_r & I2C_KEEP_MASK) | I2C_FLAG_RST;
      end else if (wr_en & (wb_adr_i == ADDR_I2C_CTRL)) begin
         i2c_ctrl_r <= wdat;
      end
   end

   // Pin synchronisers, two flip-flops each
   // Reset to the idle pin levels (clock low, data high, select high) so no false edge follows reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sync1_r <= 3'h3;
         sync2_r <= 3'h3;
      end else begin
         sync1_r <= {pins_i.sck, pins_i.sdi, pins_i.scs_n};
         sync2_r <= sync1_r;
      end
   end

   // Edge history of synchronised clock and select
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sck_prev_r <= 1'b0;
         scs_prev_r <= 1'b1;
      end else begin
         sck_prev_r <= sck_s;
         scs_prev_r <= scs_n_s;
      end
   end

   // Bit counter and receive shifter; counter cleared after select release or disable, shifter holds
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bit_cnt_r <= BIT_CNT_ZERO;
         shift_r   <= 8'h00;
      end else if (~selected) begin
         // (R3) Held idle while disabled or deselected; count survives one cycle for abort check
         if (~scs_prev_r | ~module_enable) begin
            bit_cnt_r <= BIT_CNT_ZERO;
         end
      end else if (sample_edge) begin
         // (R15) Count sampled bits toward eight
         bit_cnt_r <= bit_cnt_r + 3'h1;
         shift_r   <= bit_order_select ? {shift_r[6:0], sdi_s} : {sdi_s, shift_r[7:1]};
      end
   end

   // Data register: software load, or received byte on completion
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         data_r <= 8'h00;
      end else if (byte_done) begin
         data_r <= bit_order_select ? {shift_r[6:0], sdi_s} : {sdi_s, shift_r[7:1]};
      end else if (wr_en & (wb_adr_i == ADDR_DATA)) begin
         data_r <= wdat;
      end
   end

   // Transmit shifter: reloads from data when a byte starts
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_r  <= 8'h00;
         sdo_r <= 1'b0;
      end else if (~selected | (bit_cnt_r == BIT_CNT_ZERO & ~sck_rise & ~sck_fall)) begin
         tx_r  <= data_r;
         sdo_r <= bit_order_select ? data_r[7] : data_r[0];
      end else if (shift_edge) begin
         tx_r  <= bit_order_select ? {tx_r[6:0], 1'b0} : {1'b0, tx_r[7:1]};
         sdo_r <= bit_order_select ? tx_r[6] : tx_r[1];
      end
   end

   // Interrupt status: events set, write one clears, set wins
   // (R10) Abort raises interrupt request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status_r <= IRQ_RST;
      end else begin
         if (wr_en & (wb_adr_i == ADDR_IRQ_STATUS)) begin
            irq_status_r <= irq_status_r & ~wdat[1:0];
         end
         if (byte_done | abort_evt) begin
            irq_status_r[IRQ_TRF_BIT] <= 1'b1;
         end
         if (abort_evt | sw_icf_set) begin
            irq_status_r[IRQ_ICF_BIT] <= 1'b1;
         end
      end
   end

   // Interrupt mask
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_mask_r <= IRQ_RST;
      end else if (wr_en & (wb_adr_i == ADDR_IRQ_MASK)) begin
         irq_mask_r <= wdat[1:0];
      end
   end

   // Level interrupt from unmasked sticky bits
   assign irq_o = |(irq_status_r & irq_mask_r);

   // Bus outputs
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdata_r;

   // Whole pin bundle in one assignment, so the output has a single driver
   // Shift clock generation for master mode lives elsewhere; only the idle level is driven here
   // Slave drives data only while selected, so a shared line stays free otherwise
   assign pins_o = '{
      // (R12) Master clock idles low when polarity bit is one
      sck:         ~clock_idle_polarity,
      // (R13) Clock driven only in master mode
      sck_oe:      module_enable & is_spi_master,
      sdo:         sdo_r,
      sdo_oe:      module_enable & (is_spi_master | selected),
      // (R2) Pins revert to plain use while disabled or no serial mode chosen
      serial_func: module_enable & (mode_sel != MODE_NONE)
   };

endmodule

// ### smeab_chk.sv
// Checker for the enable and slave abort block, bound to its top module.
// Sees only the top ports; shadows the mode, SPI control and interrupt mask register bytes.
`timescale 1ns/10ps
module smeab_chk
   import smeab_pkg::*;
(
   input wire logic            clk_i,
   input wire logic            rst_i,
   input wire logic            wb_cyc_i,
   input wire logic            wb_stb_i,
   input wire logic            wb_we_i,
   input wire logic [7:0]      wb_adr_i,
   input wire logic [3:0]      wb_sel_i,
   input wire logic [31:0]     wb_dat_i,
   input wire logic [31:0]     wb_dat_o,
   input wire logic            wb_ack_o,
   input wire smeab_pins_in_s  pins_i,
   input wire smeab_pins_out_s pins_o,
   input wire logic            irq_o
);
   logic [7:0] mode_r; // Last mode byte written
   logic [7:0] spi_r;  // Last SPI byte written
   logic [7:0] mask_r; // Last mask byte written
   logic       wr;     // Write lands at this edge
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
   // Shadows follow writes only; hardware flags are not tracked
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode_r <= MODE_CTRL_RST;
         spi_r  <= SPI_CTRL_RST;
         mask_r <= 8'h00;
      end else if (wr) begin
         case (wb_adr_i)
            ADDR_MODE_CTRL: mode_r <= wb_dat_i[7:0];
            ADDR_SPI_CTRL:  spi_r <= wb_dat_i[7:0];
            ADDR_IRQ_MASK:  mask_r <= wb_dat_i[7:0];
            default:        mask_r <= mask_r;
         endcase
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_take;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_mode_wr;
      wr && wb_adr_i == ADDR_MODE_CTRL;
   endsequence
   sequence s_spi_wr;
      wr && wb_adr_i == ADDR_SPI_CTRL;
   endsequence
   ack_timing_a: assert property (s_take |=> wb_ack_o) else $error("ack late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
   read_upper_a: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits");
   unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > ADDR_IRQ_MASK |-> wb_dat_o == 32'h0)
      else $error("unmapped read");
   func_track_a: assert property (s_mode_wr |=> ##1
      pins_o.serial_func == (mode_r[MODE_EN_BIT] && mode_r[7:5] != MODE_NONE)) else $error("pin function");
   off_quiet_a: assert property ((!mode_r[MODE_EN_BIT]) [*2] |->
      !(pins_o.sck_oe || pins_o.sdo_oe || pins_o.serial_func)) else $error("off but active");
   sck_idle_a: assert property (s_spi_wr |=> ##1 pins_o.sck == !spi_r[SPI_POL_BIT]) else $error("idle");
   irq_masked_a: assert property ($rose(irq_o) |-> mask_r[1:0] != 2'h0) else $error("masked irq");
endmodule
bind smeab_top smeab_chk smeab_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .pins_i(pins_i), .pins_o(pins_o), .irq_o(irq_o));

// ### smeab_spi_master.sv
// External SPI master model for the slave pins.
// Assumes one caller at a time; clock stands low between frames.
`timescale 1ns/10ps
module smeab_spi_master (
   input  logic sdo_i,
   output logic sck_o,
   output logic sdi_o,
   output logic scs_n_o
);
   localparam int HALF_NS = 400; // Half of an 800 ns period
   logic [7:0] rx_q;             // Bits taken from the slave data line, newest in bit 0
   initial begin
      rx_q    = 8'h00;
      sck_o   = 1'b0;
      sdi_o   = 1'b1;
      scs_n_o = 1'b1;
   end
   // Shifts the top n bits of b, MSB first; n below 8 aborts
   task automatic send(input int n, input logic [7:0] b);
      #37;
      scs_n_o = 1'b0;
      for (int i = 0; i < n; i++) begin
         sdi_o = b[7-i];
         #HALF_NS;
         sck_o = 1'b1;
         // Slave output has settled within the half period since the falling clock; take it on the rising clock
         rx_q = {rx_q[6:0], sdo_i};
         #HALF_NS;
         sck_o = 1'b0;
      end
      #HALF_NS;
      scs_n_o = 1'b1;
      // Released line must not look like a held bit
      sdi_o = ~sdi_o;
   endtask
endmodule

// ### smeab_top_test.sv
// Self-checking bench for the enable and slave abort block.
// Assumes the SPI master model and the bound checker.
`timescale 1ns/10ps
module smeab_top_test
   import smeab_pkg::*;
;
   logic            clk_i;
   logic            rst_i;
   logic            wb_cyc_i;
   logic            wb_stb_i;
   logic            wb_we_i;
   logic [7:0]      wb_adr_i;
   logic [3:0]      wb_sel_i;
   logic [31:0]     wb_dat_i;
   logic [31:0]     wb_dat_o;
   logic            wb_ack_o;
   smeab_pins_in_s  pins_i;
   smeab_pins_out_s pins_o;
   logic            irq_o;
   logic            sck;
   logic            sdi;
   logic            scs_n;
   logic [7:0]      rd_q;     // Last read byte
   int              n_fail;
   int              n_checks;
   assign pins_i = {sck, sdi, scs_n};
   smeab_top smeab_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .pins_i(pins_i), .pins_o(pins_o), .irq_o(irq_o));
   smeab_spi_master smeab_spi_master_inst (.sdo_i(pins_o.sdo), .sck_o(sck), .sdi_o(sdi), .scs_n_o(scs_n));
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp, input string what);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s got %b", $time, what, got);
      end
   endtask
   // One classic cycle; held until ack is seen high
   task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_sel_i <= 4'h1;
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rd_q = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, d);
      repeat (2) @(posedge clk_i);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      wb(1'b0, a, 8'h00);
      chk8(rd_q, exp, what);
   endtask
   // Lets the two-stage pin synchronisers and flag logic finish
   task automatic frame(input int n, input logic [7:0] b);
      smeab_spi_master_inst.send(n, b);
      repeat (10) @(posedge clk_i);
   endtask
   task automatic t_basic;
      rd(ADDR_MODE_CTRL, 8'he0, "mode reset");
      rd(ADDR_SPI_CTRL, 8'h00, "spi reset");
      rd(8'h1c, 8'h00, "unmapped");
      chk1(pins_o.sck, 1'b1, "idle high");
      wr(ADDR_MODE_CTRL, 8'ha2);
      chk1(pins_o.serial_func, 1'b1, "func on");
      wr(ADDR_SPI_CTRL, 8'h20);
      chk1(pins_o.sck, 1'b0, "idle low");
      wr(ADDR_MODE_CTRL, 8'ha0);
      chk1(pins_o.serial_func, 1'b0, "func off");
      chk1(pins_o.sdo_oe | pins_o.sck_oe, 1'b0, "quiet");
      $display("basic done");
   endtask
   task automatic t_abort;
      wr(ADDR_SPI_CTRL, 8'h1c);
      wr(ADDR_IRQ_MASK, 8'h03);
      wr(ADDR_MODE_CTRL, 8'ha2);
      rd(ADDR_SPI_CTRL, 8'h1c, "spi kept");
      wr(ADDR_DATA, 8'h3c);
      frame(8, 8'ha5);
      chk8(smeab_spi_master_inst.rx_q, 8'h3c, "tx byte");
      rd(ADDR_DATA, 8'ha5, "rx byte");
      rd(ADDR_MODE_CTRL, 8'ha2, "no abort");
      rd(ADDR_SPI_CTRL, 8'h1d, "done flag");
      wr(ADDR_IRQ_STATUS, 8'h03);
      wr(ADDR_SPI_CTRL, 8'h1c);
      frame(3, 8'hc0);
      rd(ADDR_MODE_CTRL, 8'ha3, "abort flag");
      rd(ADDR_SPI_CTRL, 8'h1d, "abort done");
      rd(ADDR_IRQ_STATUS, 8'h03, "events");
      chk1(irq_o, 1'b1, "irq up");
      wr(ADDR_IRQ_MASK, 8'h00);
      chk1(irq_o, 1'b0, "irq masked");
      wr(ADDR_IRQ_MASK, 8'h03);
      wr(ADDR_IRQ_STATUS, 8'h03);
      chk1(irq_o, 1'b0, "irq cleared");
      $display("abort done");
   endtask
   task automatic t_guard;
      wr(ADDR_MODE_CTRL, 8'ha2);
      wr(ADDR_SPI_CTRL, 8'h18);
      frame(3, 8'hc0);
      rd(ADDR_MODE_CTRL, 8'ha2, "select off");
      rd(ADDR_IRQ_STATUS, 8'h00, "no event");
      wr(ADDR_SPI_CTRL, 8'h1c);
      wr(ADDR_MODE_CTRL, 8'hc2);
      frame(3, 8'hc0);
      rd(ADDR_MODE_CTRL, 8'hc2, "i2c no flag");
      wr(ADDR_MODE_CTRL, 8'ha3);
      rd(ADDR_MODE_CTRL, 8'ha3, "soft flag");
      rd(ADDR_SPI_CTRL, 8'h1c, "done kept");
      rd(ADDR_IRQ_STATUS, 8'h02, "soft event");
      wr(ADDR_MODE_CTRL, 8'hc0);
      wr(ADDR_I2C_CTRL, 8'hdf);
      wr(ADDR_MODE_CTRL, 8'hc2);
      rd(ADDR_I2C_CTRL, 8'hc1, "i2c rise");
      $display("guard done");
   endtask
   task automatic end_of_test;
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Whole run needs well under a millisecond
   initial begin
      #1_000_000;
      n_fail++;
      $display("[ERR] %0t watchdog", $time);
      end_of_test;
   end
   initial begin
      n_fail   = 0;
      n_checks = 0;
      rst_i    = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i  = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h1;
      wb_dat_i = 32'h0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      t_basic;
      t_abort;
      t_guard;
      end_of_test;
   end
endmodule
